//--- src/aosc_pkg.sv
// Purpose: Shared constants, types and arithmetic for the analog output set-value control.
// Assumes: 20 MHz system clock, classic Wishbone register access, 16-bit data in the low lanes.
// Notes: Converter codes are signed counts where 0 is 0 V on every range.
package aosc_pkg;
	// Timing
	localparam int CLK_HZ         = 20_000_000;
	localparam int CONV_PERIOD_MS = 40;
	localparam int NUM_CH         = 4;
	localparam int SLOT_CYC       = CLK_HZ / 1000 * CONV_PERIOD_MS / NUM_CH;
	// Exchange and setting areas
	localparam int XW_WORDS  = 10;
	localparam int DM_WORDS  = 100;
	localparam int DM_STRIDE = 8;
	localparam logic [11:0] ADR_XW     = 12'h000;
	localparam logic [11:0] ADR_DM     = 12'h100;
	localparam logic [11:0] ADR_DM_END = 12'h290;
	localparam logic [11:0] ADR_HOST   = 12'h300;
	localparam logic [11:0] ADR_STAT   = 12'h304;
	// Per-channel setting word positions
	localparam logic [6:0] F_RANGE  = 7'h00;
	localparam logic [6:0] F_SMIN   = 7'h01;
	localparam logic [6:0] F_SMAX   = 7'h02;
	localparam logic [6:0] F_HLIM   = 7'h03;
	localparam logic [6:0] F_LLIM   = 7'h04;
	localparam logic [6:0] F_RATE   = 7'h05;
	localparam logic [6:0] F_HMODE  = 7'h06;
	localparam logic [6:0] F_PRESET = 7'h07;
	// Host status register bits
	localparam int HB_FATAL   = 0;
	localparam int HB_CPUERR  = 1;
	localparam int HB_OUTOFF  = 2;
	localparam int HB_LOADOFF = 3;
	localparam int HB_STANDBY = 4;
	localparam int HB_MEMHOLD = 5;
	localparam int HB_MODE    = 6;
	localparam logic [7:0] HOST_RST = 8'h10;
	// Set value limits
	localparam logic signed [15:0] SET_MAX = 16'sh7D00;
	localparam logic signed [15:0] SET_MIN = 16'sh8300;
	localparam logic [15:0] XW_RST = 16'h0000;

	typedef enum logic [1:0] {
		MODE_PROG = 2'b00,
		MODE_MON  = 2'b01,
		MODE_RUN  = 2'b10
	} aosc_mode_t;

	typedef enum logic [2:0] {
		RNG_U10 = 3'b000,
		RNG_U5  = 3'b001,
		RNG_U1  = 3'b010,
		RNG_B10 = 3'b011,
		RNG_B5  = 3'b100,
		RNG_B1  = 3'b101
	} aosc_range_t;

	// Counts per full scale of a range
	function automatic logic signed [16:0] res_of(input logic [2:0] r);
		case (r)
			RNG_B10, RNG_B1: res_of = 17'sd16000;
			RNG_U5:          res_of = 17'sd4000;
			default:         res_of = 17'sd8000;
		endcase
	endfunction

	function automatic logic is_bip(input logic [2:0] r);
		is_bip = (r == RNG_B10) || (r == RNG_B5) || (r == RNG_B1);
	endfunction

	function automatic logic narrow_band(input logic [2:0] r);
		narrow_band = (r == RNG_B10) || (r == RNG_B1);
	endfunction

	// Lowest and highest count the range allows
	function automatic logic signed [16:0] lo_of(input logic [2:0] r);
		lo_of = narrow_band(r) ? 17'(-(int'(res_of(r)) * 75 / 1000)) : 17'(-(int'(res_of(r)) * 15 / 100));
	endfunction

	function automatic logic signed [16:0] hi_of(input logic [2:0] r);
		hi_of = narrow_band(r) ? 17'(int'(res_of(r)) * 1075 / 1000) : 17'(int'(res_of(r)) * 115 / 100);
	endfunction
endpackage

//--- src/aosc_scale.sv
// Purpose: Scales one engineering-unit set value to converter counts and applies the high/low limits.
// Assumes: Purely combinational path; clock and reset feed only the checks.
// Notes: Equal scale endpoints give zero counts rather than a divide by zero.
`timescale 1ns/1ps
module aosc_scale
	import aosc_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic signed [15:0] value_in,
	input  wire logic signed [15:0] smin_in,
	input  wire logic signed [15:0] smax_in,
	input  wire logic        [2:0]  range_in,
	input  wire logic signed [15:0] hlim_in,
	input  wire logic signed [15:0] llim_in,
	output logic signed      [15:0] count_out
);
	logic signed [33:0] num;
	logic signed [33:0] den;
	logic signed [33:0] scaled;
	logic signed [33:0] limited;

	// Linear map of min..max data onto 0..full scale, then limits
	always_comb
	begin
		num = (34'(value_in) - 34'(smin_in)) * 34'(res_of(range_in)); // R11
		den = 34'(smax_in) - 34'(smin_in);
		scaled = (den == 34'sh0) ? 34'sh0 : num / den; // R11 R20
		limited = scaled;
		if (limited > 34'(hlim_in))
			limited = 34'(hlim_in); // R17
		if (limited < 34'(llim_in))
			limited = 34'(llim_in); // R17
		count_out = limited[15:0];
	end

	chk_limit_band: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R17
		(llim_in <= hlim_in) |-> (count_out <= hlim_in && count_out >= llim_in))
		else $error("scaled count outside high/low limits");
	chk_scale_ends: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R11
		(value_in == smin_in && llim_in <= 16'sh0 && hlim_in >= 16'sh0) |-> count_out == 16'sh0)
		else $error("minimum set value does not give zero counts");
endmodule

//--- src/aosc_top.sv
// Purpose: Set-value control of a four-channel analog output unit behind a Wishbone register slave.
// Assumes: Host writes exchange words, setting words and its own status into registers each cycle.
// Notes: One channel is converted per slot; four slots make one conversion period.
//
// How it works
// R1 - Host errors or output-off hold previous or preset
// R2 - Program mode without memory hold clears channel words
// R3 - Program mode with memory hold keeps channel words
// R4 - Zero output until host first leaves standby
// R5 - Without cyclic refresh host refreshes by instruction
// R6 - Conversion continues in every host mode
// R7 - Up to four channel values converted each period
// R8 - Ten exchange words, host writes, nothing returned; a read here returns the stored word
// R9 - Hundred setting words hold limits and scaling
// R10 - Each channel picks one of six ranges
// R11 - Min and max data map onto range
// R12 - Channel words saturate to plus minus 32000
// R13 - Count resolution depends on selected range
// R14 - All four channels converted within 40 ms
// R15 - Output limited to range percentage band
// R16 - Host sets unique unit number 00 to 95
// R17 - Clamp to configured high and low limits
// R18 - Limit output change per refresh by rate
// R19 - Load interruption also holds; error clear resumes
// R20 - Scale, limit, rate limit, range clamp order
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module aosc_top
	import aosc_pkg::*;
#(
	parameter int SLOT_CYCLES = SLOT_CYC,
	parameter int NUM_CHAN    = NUM_CH
)(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [11:0] wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	output logic      [15:0] dac_data_out,
	output logic      [1:0]  dac_chan_out,
	output logic      [2:0]  dac_range_out,
	output logic             dac_load_out
);
	localparam int SW = $clog2(SLOT_CYCLES);

	// Elaboration checks
	if (NUM_CHAN != NUM_CH)
		$error("only four channels are supported");
	if (SLOT_CYCLES < 16)
		$error("slot must be at least 16 cycles");

	// Merge byte lanes of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Saturate a signed channel word to the legal set range
	function automatic logic [15:0] sat_set(input logic [15:0] v);
		if ($signed(v) > SET_MAX)
			sat_set = SET_MAX;
		else if ($signed(v) < SET_MIN)
			sat_set = SET_MIN;
		else
			sat_set = v;
	endfunction

	// Range clamp then shift so that 0 is 0 V
	function automatic logic [15:0] to_code(input logic signed [16:0] v, input logic [2:0] r);
		logic signed [16:0] c;
		c = v;
		if (c > hi_of(r))
			c = hi_of(r);
		if (c < lo_of(r))
			c = lo_of(r);
		if (is_bip(r))
			c = c - (res_of(r) >>> 1);
		to_code = c[15:0];
	endfunction

	// Register storage
	logic [15:0]   xw [XW_WORDS];
	logic [15:0]   next_xw [XW_WORDS];
	logic [15:0]   dm [DM_WORDS];
	logic [15:0]   next_dm [DM_WORDS];
	logic [7:0]    host;
	logic [7:0]    next_host;
	logic [31:0]   next_wb_dat;
	logic          next_wb_ack;

	// Sequencer state
	logic [SW-1:0] slot_cnt;
	logic [SW-1:0] next_slot_cnt;
	logic [1:0]    ch;
	logic [1:0]    next_ch;
	logic [15:0]   last [NUM_CH];
	logic [15:0]   next_last [NUM_CH];
	logic          up_ok;
	logic          next_up_ok;
	logic [15:0]   next_dac_data;
	logic [2:0]    next_dac_range;
	logic          next_dac_load;
	logic [1:0]    next_dac_chan;

	// Decode
	logic          req;
	logic          hit_xw;
	logic          hit_dm;
	logic [11:0]   dm_off;
	logic [6:0]    di;
	logic [3:0]    xi;
	logic [6:0]    base;
	logic [2:0]    rng;
	logic          hold_act;
	logic          slot_end;
	logic [15:0]   scaled;
	logic signed [16:0] diff;
	logic signed [16:0] step;
	logic          mode_to_prog;

	assign req      = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign hit_xw   = wb_adr_in < (ADR_XW + 12'(XW_WORDS * 4));
	assign hit_dm   = wb_adr_in >= ADR_DM && wb_adr_in < ADR_DM_END;
	assign dm_off   = wb_adr_in - ADR_DM;
	assign di       = dm_off[8:2];
	assign xi       = wb_adr_in[5:2];
	assign base     = 7'(ch) * 7'(DM_STRIDE);
	assign rng      = dm[base + F_RANGE][2:0];
	assign slot_end = slot_cnt == SW'(SLOT_CYCLES - 1);
	assign hold_act = host[HB_FATAL] || host[HB_CPUERR] || host[HB_OUTOFF] || host[HB_LOADOFF]; // R1 R19
	assign mode_to_prog = req && wb_we_in && wb_adr_in == ADR_HOST && wb_sel_in[0]
		&& host[HB_MODE +: 2] != MODE_PROG && wb_dat_in[HB_MODE +: 2] == MODE_PROG;

	// Scaling and high/low limits for the channel in its slot
	aosc_scale u_scale (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.value_in  ($signed(xw[ch])),
		.smin_in   ($signed(dm[base + F_SMIN])),
		.smax_in   ($signed(dm[base + F_SMAX])),
		.range_in  (rng),
		.hlim_in   ($signed(dm[base + F_HLIM])),
		.llim_in   ($signed(dm[base + F_LLIM])),
		.count_out (scaled)
	);

	// Register writes and bus answer
	always_comb
	begin
		next_xw     = xw;
		next_dm     = dm;
		next_host   = host;
		next_wb_ack = req;
		next_wb_dat = 32'h0000_0000;
		if (req && wb_we_in)
		begin
			if (hit_xw)
				next_xw[xi] = (xi < 4'(NUM_CH)) ? sat_set(merge16(xw[xi], wb_dat_in, wb_sel_in)) // R8 R12
					: merge16(xw[xi], wb_dat_in, wb_sel_in);
			else if (hit_dm)
				next_dm[di] = merge16(dm[di], wb_dat_in, wb_sel_in); // R9
			else if (wb_adr_in == ADR_HOST && wb_sel_in[0])
				next_host = wb_dat_in[7:0];
			// Memory hold set skips the clear, so channel words keep their value
			if (mode_to_prog && !wb_dat_in[HB_MEMHOLD]) // R3
				for (int i = 0; i < NUM_CH; i++)
					next_xw[i] = XW_RST; // R2
		end
		else if (req)
		begin
			if (hit_xw)
				next_wb_dat = {16'h0000, xw[xi]};
			else if (hit_dm)
				next_wb_dat = {16'h0000, dm[di]};
			else if (wb_adr_in == ADR_HOST)
				next_wb_dat = {24'h00_0000, host};
			else if (wb_adr_in == ADR_STAT)
				next_wb_dat = {28'h000_0000, up_ok, hold_act, ch};
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < XW_WORDS; i++)
				xw[i] <= XW_RST;
			for (int i = 0; i < DM_WORDS; i++)
				dm[i] <= 16'h0000;
			host       <= HOST_RST;
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end
		else
		begin
			xw         <= next_xw;
			dm         <= next_dm;
			host       <= next_host;
			wb_ack_out <= next_wb_ack;
			wb_dat_out <= next_wb_dat;
		end
	end

	// Conversion sequencer: one channel per slot, never paused by host mode
	always_comb
	begin
		next_slot_cnt  = slot_end ? '0 : slot_cnt + 1'b1; // R6 R14
		next_ch        = slot_end ? ch + 2'd1 : ch; // R7
		next_last      = last;
		next_up_ok     = up_ok || (!host[HB_STANDBY] && !host[HB_FATAL]); // R4
		next_dac_load  = slot_end;
		next_dac_chan  = slot_end ? ch : dac_chan_out;
		next_dac_range = slot_end ? rng : dac_range_out; // R10
		next_dac_data  = dac_data_out;
		diff = 17'($signed(scaled)) - 17'($signed(last[ch]));
		step = 17'($signed({1'b0, dm[base + F_RATE][14:0]}));
		if (slot_end)
		begin
			if (!up_ok)
				next_dac_data = 16'h0000; // R4
			else
			begin
				if (hold_act)
				begin
					if (dm[base + F_HMODE][0])
						next_last[ch] = dm[base + F_PRESET]; // R1
				end
				else if (step != 17'sh0 && diff > step)
					next_last[ch] = 16'(17'($signed(last[ch])) + step); // R18 R20
				else if (step != 17'sh0 && diff < -step)
					next_last[ch] = 16'(17'($signed(last[ch])) - step); // R18
				else
					next_last[ch] = scaled; // R19
				next_dac_data = to_code(17'($signed(next_last[ch])), rng); // R13 R15 R20
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			slot_cnt      <= '0;
			ch            <= 2'd0;
			for (int i = 0; i < NUM_CH; i++)
				last[i] <= 16'h0000;
			up_ok         <= 1'b0;
			dac_data_out  <= 16'h0000;
			dac_chan_out  <= 2'd0;
			dac_range_out <= 3'd0;
			dac_load_out  <= 1'b0;
		end
		else
		begin
			slot_cnt      <= next_slot_cnt;
			ch            <= next_ch;
			last          <= next_last;
			up_ok         <= next_up_ok;
			dac_data_out  <= next_dac_data;
			dac_chan_out  <= next_dac_chan;
			dac_range_out <= next_dac_range;
			dac_load_out  <= next_dac_load;
		end
	end

	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_conv;
		slot_end && up_ok;
	endsequence
	sequence s_prog_entry;
		mode_to_prog;
	endsequence

	chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out) // R8
		else $error("ack held longer than one cycle");
	chk_prog_clear: assert property ((s_prog_entry and !wb_dat_in[HB_MEMHOLD]) |=> // R2
		xw[0] == 16'h0000 && xw[3] == 16'h0000)
		else $error("channel words not cleared on program entry");
	chk_prog_keep: assert property ((s_prog_entry and wb_dat_in[HB_MEMHOLD]) |=> xw[1] == $past(xw[1])) // R3
		else $error("channel word changed on program entry with hold");
	chk_zero_start: assert property (slot_end && !up_ok |=> dac_load_out && dac_data_out == 16'h0000) // R4
		else $error("nonzero output before host ready");
	chk_load_space: assert property (dac_load_out |=> (!dac_load_out) [*8]) // R14
		else $error("conversion loads too close");
	chk_slot_bound: assert property ((slot_cnt <= SW'(SLOT_CYCLES - 1)) and (slot_end |=> slot_cnt == '0)) // R6
		else $error("slot counter escaped its period");
	chk_chan_next: assert property (s_conv |=> dac_chan_out == $past(ch) && ch == $past(ch) + 2'd1) // R7
		else $error("channel order broken");
	chk_range_band: assert property (dac_load_out && up_ok |-> // R15
		$signed(dac_data_out) <= 16'(hi_of(dac_range_out) - (is_bip(dac_range_out) ? res_of(dac_range_out) >>> 1 : 17'sh0))
		&& $signed(dac_data_out) >= 16'(lo_of(dac_range_out) - (is_bip(dac_range_out) ? res_of(dac_range_out) >>> 1 : 17'sh0)))
		else $error("output beyond range band");
	chk_hold_prev: assert property ((s_conv and (hold_act && !dm[base + F_HMODE][0])) |=> // R1
		last[$past(ch)] == $past(last[ch]))
		else $error("held channel value changed");
	chk_rate_step: assert property ((s_conv and (!hold_act && step != 17'sh0)) |=> // R18
		($signed(last[$past(ch)]) - $signed($past(last[ch]))) <= $past(step)
		&& ($signed($past(last[ch])) - $signed(last[$past(ch)])) <= $past(step))
		else $error("rate limit exceeded");
endmodule

//--- test/aosc_host.sv
// Purpose: Host controller model that writes set values and settings over classic Wishbone.
// Assumes: Requests launch just after a rising edge; the answer is taken at a rising edge.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
module aosc_host
#(
	parameter int UNIT_NUM = 7
)(
	input  wire logic        clk_in,
	input  wire logic        ack_in,
	input  wire logic [31:0] dat_in,
	output logic             cyc_out,
	output logic             stb_out,
	output logic             we_out,
	output logic      [11:0] adr_out,
	output logic      [3:0]  sel_out,
	output logic      [31:0] dat_out
);
	// Unit number must lie in the selectable span
	if (UNIT_NUM < 0 || UNIT_NUM > 95)
		$error("unit number out of range");
	// Idle bus at time zero
	initial
	begin
		cyc_out = 1'b0;
		stb_out = 1'b0;
		we_out  = 1'b0;
		adr_out = 12'h000;
		sel_out = 4'h0;
		dat_out = 32'h00000000;
	end
	// One classic cycle carrying a whole 16-bit word on the low lanes
	// Answer is sampled at the rising edge; only the bench watchdog ends a wait
	task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [15:0] q);
		@(posedge clk_in);
		cyc_out <= 1'b1;
		stb_out <= 1'b1;
		we_out  <= w;
		adr_out <= a;
		sel_out <= 4'h3;
		dat_out <= {16'h0000, d};
		@(posedge clk_in);
		while (ack_in !== 1'b1)
			@(posedge clk_in);
		q = dat_in[15:0];
		cyc_out <= 1'b0;
		stb_out <= 1'b0;
		we_out  <= 1'b0;
		adr_out <= ~a;
		dat_out <= ~{16'h0000, d};
	endtask
endmodule

//--- test/tb_top.sv
// Purpose: Self-checking bench for the set-value control block.
// Assumes: Short slot of 32 cycles; channel 0 carries the traffic.
// Notes: A monitor checks every load for channel order and every load after the first for spacing.
`timescale 1ns/1ps
module tb_top;
	import aosc_pkg::*;
	localparam int SLOT = 32;
	logic        clk_in;
	logic        rst_n_in;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [11:0] adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic [15:0] dac_data_out;
	logic [1:0]  dac_chan_out;
	logic [2:0]  dac_range_out;
	logic        dac_load_out;
	logic [1:0]  exp_ch;
	logic [2:0]  rng_exp;
	int          gap;
	bit          seen;
	int          mismatches;
	int          n_compared;
	aosc_host host (.clk_in(clk_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc), .stb_out(stb),
		.we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));
	aosc_top #(.SLOT_CYCLES(SLOT)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .dac_data_out(dac_data_out), .dac_chan_out(dac_chan_out),
		.dac_range_out(dac_range_out), .dac_load_out(dac_load_out));
	// Clock of 50 ns
	initial
	begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// Counts per full scale
	function automatic int res_f(input logic [2:0] r);
		return (r == 3'h3 || r == 3'h5) ? 16000 : ((r == 3'h1) ? 4000 : 8000);
	endfunction
	// Range band clamp, then bipolar offset
	function automatic logic [15:0] exp_code(input logic [2:0] r, input int c);
		int res;
		int lo;
		int hi;
		res = res_f(r);
		lo = (res == 16000) ? -res * 75 / 1000 : -res * 15 / 100;
		hi = (res == 16000) ? res * 1075 / 1000 : res * 115 / 100;
		c = (c < lo) ? lo : ((c > hi) ? hi : c);
		if (r >= 3'h3)
			c = c - res / 2;
		return 16'(c);
	endfunction
	task automatic chk_val(input logic [15:0] q, input logic [15:0] e, input string what);
		n_compared++;
		if (q !== e)
		begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, q, e);
		end
	endtask
	task automatic chk_reg(input logic [11:0] a, input logic [15:0] e);
		logic [15:0] q;
		host.xfer(1'b0, a, 16'h0000, q);
		chk_val(q, e, "register read");
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [15:0] q;
		host.xfer(1'b1, a, d, q);
	endtask
	task automatic cfg(input logic [6:0] f, input logic [15:0] d);
		wr(ADR_DM + {3'b000, f, 2'b00}, d);
	endtask
	// Next load of channel 0
	task automatic ld0(output logic [15:0] q);
		int n;
		n = 0;
		do
		begin
			@(negedge clk_in);
			n++;
		end
		while (!(dac_load_out === 1'b1 && dac_chan_out === 2'd0) && n < 8 * SLOT);
		// A missing load counts against the run
		if (n >= 8 * SLOT)
		begin
			mismatches++;
			$display("wrong value at %0t: no channel 0 load", $time);
		end
		q = dac_data_out;
	endtask
	task automatic conv_chk(input logic [15:0] e);
		logic [15:0] q;
		ld0(q);
		ld0(q);
		chk_val(q, e, "converter code");
		chk_val({13'h0, dac_range_out}, {13'h0, rng_exp}, "range code");
	endtask
	task automatic tend(input string name);
		$display("Test %s done: %0d compared, %0d mismatches", name, n_compared, mismatches);
	endtask
	task automatic test_done();
		$display("Counts: %0d compared, %0d mismatches", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Load spacing and channel order monitor
	always @(negedge clk_in)
	begin
		gap = gap + 1;
		if (rst_n_in !== 1'b1)
		begin
			gap = 0;
			seen = 1'b0;
			exp_ch = 2'd0;
		end
		else if (dac_load_out === 1'b1)
		begin
			if (seen)
				chk_val(16'(gap), 16'(SLOT), "load spacing");
			chk_val({14'h0, dac_chan_out}, {14'h0, exp_ch}, "channel order");
			exp_ch = exp_ch + 2'd1;
			gap = 0;
			seen = 1'b1;
		end
	end
	// Watchdog
	initial
	begin
		repeat (60000) @(posedge clk_in);
		mismatches++;
		test_done();
	end
	// Main sequence
	initial
	begin
		logic [15:0] v;
		mismatches = 0;
		n_compared = 0;
		rng_exp = 3'h0;
		rst_n_in = 1'b0;
		v = 16'($urandom(32'h8d72));
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		chk_reg(ADR_HOST, {8'h00, HOST_RST});
		chk_reg(ADR_XW, XW_RST);
		wr(12'hFF0, 16'hBEEF);
		chk_reg(12'hFF0, 16'h0000);
		wr(ADR_XW, 16'h8000);
		chk_reg(ADR_XW, SET_MIN);
		wr(ADR_XW, 16'h7FFF);
		chk_reg(ADR_XW, SET_MAX);
		tend("registers");
		cfg(F_SMAX, 16'd8000);
		cfg(F_HLIM, 16'h7FFF);
		cfg(F_LLIM, 16'h8000);
		wr(ADR_XW, 16'd1000);
		conv_chk(16'h0000);
		wr(ADR_HOST, 16'h0080);
		conv_chk(16'd1000);
		tend("power-up");
		for (int r = 0; r < 6; r++)
		begin
			cfg(F_RANGE, 16'(r));
			rng_exp = 3'(r);
			cfg(F_SMAX, 16'(res_f(3'(r))));
			repeat (2)
			begin
				v = 16'(int'($urandom_range(64000)) - 32000);
				wr(ADR_XW, v);
				conv_chk(exp_code(3'(r), int'($signed(v))));
			end
		end
		cfg(F_RANGE, 16'h0000);
		rng_exp = 3'h0;
		cfg(F_SMAX, 16'd8000);
		tend("ranges");
		// Set value well above the high limit, whatever the random one was
		wr(ADR_XW, 16'd2000);
		cfg(F_HLIM, 16'd500);
		conv_chk(16'd500);
		cfg(F_LLIM, 16'hFED4);
		wr(ADR_XW, 16'hF830);
		conv_chk(16'hFED4);
		ld0(v);
		cfg(F_RATE, 16'd100);
		wr(ADR_XW, 16'd400);
		ld0(v);
		chk_val(v, 16'hFF38, "rate step");
		ld0(v);
		chk_val(v, 16'hFF9C, "rate step");
		cfg(F_RATE, 16'h0000);
		tend("limits");
		cfg(F_PRESET, 16'd123);
		for (int b = 0; b < 4; b++)
		begin
			cfg(F_HMODE, 16'(b % 2));
			wr(ADR_XW, 16'd300);
			conv_chk(16'd300);
			wr(ADR_HOST, 16'h0080 | 16'(1 << b));
			wr(ADR_XW, 16'd450);
			conv_chk((b % 2 == 1) ? 16'd123 : 16'd300);
			wr(ADR_HOST, 16'h0080);
			conv_chk(16'd450);
		end
		tend("hold");
		wr(ADR_HOST, 16'h0000);
		chk_reg(ADR_XW, 16'h0000);
		conv_chk(16'h0000);
		wr(ADR_HOST, 16'h0040);
		wr(ADR_XW, 16'd250);
		wr(ADR_HOST, 16'h0020);
		chk_reg(ADR_XW, 16'd250);
		conv_chk(16'd250);
		tend("mode change");
		test_done();
	end
endmodule
